//--- rtl/servo_command_input_select.sv
/*
  Command input front end: pulse counting and analog command routing.
  Assumes synchronous pulse inputs, a signed 16-bit converter sample with a
  one-cycle valid strobe, and a register master that never strobes read and write together.
*/
// Our own choices: the strobed register port and the register addresses.
// How it works
// - In the CW/CCW and pulse-plus-sign formats one pulse is counted per rising pulse edge, except CW and CCW edges rising in the same cycle.
// - In the quadrature format every rising and falling edge of either phase is counted, except edges of both phases in the same cycle.
// - Mode 3 uses the analog input as speed command with speed gain, inversion, offset, filter.
// - Mode 4 with select 0 uses it as torque command with torque gain, inversion, offset, filter.
// - Mode 4 with select 1 uses it as speed limit with speed gain, offset, filter, no inversion.
// - Any other control mode ignores the analog input entirely.
// - The analog input is a 16-bit signed sample whose top bit is the sign.
// - In a switching mode the analog function applies only while its sub-mode is active.
`timescale 1ns/1ps
`default_nettype none
module servo_command_input_select
  import servo_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [DATA_W-1:0]  reg_rdata,
  // Command pulse lines
  input  wire logic               command_pulse_line,
  input  wire logic               command_sign_line,
  // Converter sample
  input  wire logic signed [15:0] adc_sample,
  input  wire logic               adc_valid,
  // Switching sub-mode
  input  wire logic               second_submode_active,
  // Results
  output logic signed [15:0]      speed_command_analog,
  output logic signed [15:0]      torque_command_analog,
  output logic signed [15:0]      speed_limit_analog,
  output logic signed [31:0]      pulse_position
);

  typedef struct packed {
    logic        [3:0]  control_mode_param;
    logic               torque_command_select_param;
    logic        [1:0]  pulse_format;
    logic        [15:0] speed_input_gain_param;
    logic               speed_input_invert_param;
    logic signed [15:0] command_offset_param;
    logic        [3:0]  command_filter_param;
    logic        [15:0] torque_input_gain_param;
    logic               torque_input_invert_param;
    logic               pulse_prev;
    logic               sign_prev;
    logic signed [31:0] count;
    logic        [15:0] count_hi_snap;
    func_type           fn;
    logic        [15:0] rdata;
    logic signed [15:0] speed_out;
    logic signed [15:0] torque_out;
    logic signed [15:0] limit_out;
  } sel_state_type;

  sel_state_type s_r;
  sel_state_type s_nxt;
  logic [1:0]    rst_sync_r;
  logic          rst_sync_n;

  cond_if cb ();

  // Reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_r[1];

  function automatic func_type select_func(input logic [3:0] mode, input logic tsel,
                                           input logic sub);
    if (mode == MODE_POS_VEL && sub) begin
      return FN_SPEED;
    end else if (mode == MODE_POS_TRQ && sub) begin
      return tsel ? FN_LIMIT : FN_TORQUE;
    end else begin
      return FN_NONE;
    end
  endfunction

  function automatic logic signed [1:0] pulse_step(input logic [1:0] fmt, input logic a,
                                                   input logic b, input logic pa,
                                                   input logic pb);
    logic ea;
    logic eb;
    ea = a ^ pa;
    eb = b ^ pb;
    pulse_step = 2'sd0;
    if (fmt == FMT_CW_CCW) begin
      if (a && !pa && !(b && !pb)) begin
        pulse_step = 2'sd1;
      end else if (b && !pb && !(a && !pa)) begin
        pulse_step = -2'sd1;
      end
    end else if (fmt == FMT_PULSE_SIGN) begin
      if (a && !pa) begin
        pulse_step = b ? -2'sd1 : 2'sd1;
      end
    end else begin
      if (ea && !eb) begin
        pulse_step = (a == b) ? 2'sd1 : -2'sd1;
      end else if (eb && !ea) begin
        pulse_step = (a != b) ? 2'sd1 : -2'sd1;
      end
    end
  endfunction

  func_type           sel;
  logic signed [1:0]  step;

  always_comb begin
    sel  = select_func(s_r.control_mode_param, s_r.torque_command_select_param,
                       second_submode_active);
    step = pulse_step(s_r.pulse_format, command_pulse_line, command_sign_line,
                      s_r.pulse_prev, s_r.sign_prev);
  end

  // Conditioner feed
  assign cb.sample       = adc_sample;
  assign cb.valid        = adc_valid && (sel != FN_NONE) && (sel == s_r.fn);
  assign cb.clear        = (sel != s_r.fn);
  assign cb.gain         = (sel == FN_TORQUE) ? s_r.torque_input_gain_param
                                              : s_r.speed_input_gain_param;
  assign cb.invert       = (sel == FN_SPEED)  ? s_r.speed_input_invert_param :
                           (sel == FN_TORQUE) ? s_r.torque_input_invert_param
                                              : 1'b0;
  assign cb.offset       = s_r.command_offset_param;
  assign cb.filter_shift = s_r.command_filter_param;

  analog_conditioner u_cond (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .c          (cb.sink)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse_prev = command_pulse_line;
    s_nxt.sign_prev  = command_sign_line;
    s_nxt.count      = s_r.count + 32'(step);
    s_nxt.fn         = sel;
    s_nxt.rdata      = 16'h0000;
    // Results follow the active function only
    if (sel != s_r.fn) begin
      s_nxt.speed_out  = 16'sh0000;
      s_nxt.torque_out = 16'sh0000;
      s_nxt.limit_out  = 16'sh0000;
    end else if (cb.result_valid) begin
      if (s_r.fn == FN_SPEED) begin
        s_nxt.speed_out = cb.result;
      end else if (s_r.fn == FN_TORQUE) begin
        s_nxt.torque_out = cb.result;
      end else if (s_r.fn == FN_LIMIT) begin
        s_nxt.limit_out = cb.result;
      end
    end
    // Register writes
    if (reg_write) begin
      if (reg_addr == CTRL_OFS) begin
        s_nxt.control_mode_param          = reg_wdata[CTRL_MODE_LSB +: 4];
        s_nxt.torque_command_select_param = reg_wdata[CTRL_TSEL_BIT];
        s_nxt.pulse_format                = reg_wdata[CTRL_FMT_LSB +: 2];
        if (reg_wdata[CTRL_CLR_BIT]) begin
          s_nxt.count = 32'sh0000_0000;
        end
      end else if (reg_addr == SPEED_GAIN_OFS) begin
        s_nxt.speed_input_gain_param = reg_wdata;
      end else if (reg_addr == SPEED_INV_OFS) begin
        s_nxt.speed_input_invert_param = reg_wdata[0];
      end else if (reg_addr == OFFSET_OFS) begin
        s_nxt.command_offset_param = reg_wdata;
      end else if (reg_addr == FILTER_OFS) begin
        s_nxt.command_filter_param = reg_wdata[3:0];
      end else if (reg_addr == TORQUE_GAIN_OFS) begin
        s_nxt.torque_input_gain_param = reg_wdata;
      end else if (reg_addr == TORQUE_INV_OFS) begin
        s_nxt.torque_input_invert_param = reg_wdata[0];
      end
    end
    // Register reads, data in the next cycle only
    if (reg_read) begin
      if (reg_addr == CTRL_OFS) begin
        s_nxt.rdata = {8'h00, 1'b0, s_r.pulse_format, s_r.torque_command_select_param,
                       s_r.control_mode_param};
      end else if (reg_addr == SPEED_GAIN_OFS) begin
        s_nxt.rdata = s_r.speed_input_gain_param;
      end else if (reg_addr == SPEED_INV_OFS) begin
        s_nxt.rdata = {15'h0000, s_r.speed_input_invert_param};
      end else if (reg_addr == OFFSET_OFS) begin
        s_nxt.rdata = s_r.command_offset_param;
      end else if (reg_addr == FILTER_OFS) begin
        s_nxt.rdata = {12'h000, s_r.command_filter_param};
      end else if (reg_addr == TORQUE_GAIN_OFS) begin
        s_nxt.rdata = s_r.torque_input_gain_param;
      end else if (reg_addr == TORQUE_INV_OFS) begin
        s_nxt.rdata = {15'h0000, s_r.torque_input_invert_param};
      end else if (reg_addr == COUNT_LO_OFS) begin
        s_nxt.rdata         = s_r.count[15:0];
        s_nxt.count_hi_snap = s_r.count[31:16];
      end else if (reg_addr == COUNT_HI_OFS) begin
        s_nxt.rdata = s_r.count_hi_snap;
      end else if (reg_addr == STATUS_OFS) begin
        s_nxt.rdata = {13'h0000, cb.result_valid, s_r.fn};
      end else if (reg_addr == RESULT_OFS) begin
        s_nxt.rdata = cb.result;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_r                         <= '0;
      s_r.control_mode_param      <= MODE_RST;
      s_r.pulse_format            <= FMT_RST;
      s_r.speed_input_gain_param  <= GAIN_RST;
      s_r.torque_input_gain_param <= GAIN_RST;
      s_r.command_filter_param    <= FILTER_RST;
      s_r.fn                      <= FN_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata             = s_r.rdata;
  assign speed_command_analog  = s_r.speed_out;
  assign torque_command_analog = s_r.torque_out;
  assign speed_limit_analog    = s_r.limit_out;
  assign pulse_position        = s_r.count;

  // Checks
  default clocking cb_chk @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  logic rise_a;
  logic rise_b;
  logic edge_a;
  logic edge_b;
  logic is_quad;
  assign rise_a  = command_pulse_line && !s_r.pulse_prev;
  assign rise_b  = command_sign_line && !s_r.sign_prev;
  assign edge_a  = command_pulse_line ^ s_r.pulse_prev;
  assign edge_b  = command_sign_line ^ s_r.sign_prev;
  assign is_quad = (s_r.pulse_format == FMT_QUAD_A) || (s_r.pulse_format == FMT_QUAD_B);

  a_cwccw_rise_count: assert property (
    (s_r.pulse_format == FMT_CW_CCW) && rise_a && !rise_b && !reg_write
    |=> pulse_position == $past(pulse_position) + 32'sd1)
    else $error("CW pulse rise not counted");

  a_fall_not_counted: assert property (
    (s_r.pulse_format == FMT_PULSE_SIGN) && !rise_a && !reg_write
    |=> pulse_position == $past(pulse_position))
    else $error("Count moved without a rising pulse edge");

  a_sign_dir_count: assert property (
    (s_r.pulse_format == FMT_PULSE_SIGN) && rise_a && command_sign_line && !reg_write
    |=> pulse_position == $past(pulse_position) - 32'sd1)
    else $error("Sign high pulse not counted down");

  a_quad_every_edge: assert property (
    is_quad && (edge_a ^ edge_b) && !reg_write
    |=> pulse_position != $past(pulse_position))
    else $error("Quadrature edge not counted");

  a_speed_route: assert property (
    (sel == FN_SPEED) |-> (cb.gain == s_r.speed_input_gain_param)
                          && (cb.invert == s_r.speed_input_invert_param))
    else $error("Speed command uses wrong gain or polarity");

  a_torque_route: assert property (
    (sel == FN_TORQUE) |-> (cb.gain == s_r.torque_input_gain_param)
                           && (cb.invert == s_r.torque_input_invert_param))
    else $error("Torque command uses wrong gain or polarity");

  a_limit_no_invert: assert property (
    (sel == FN_LIMIT) |-> !cb.invert && (cb.gain == s_r.speed_input_gain_param))
    else $error("Speed limit inverted or wrong gain");

  a_other_mode_ignored: assert property (
    (s_r.control_mode_param != MODE_POS_VEL) && (s_r.control_mode_param != MODE_POS_TRQ)
    ##1 (s_r.control_mode_param != MODE_POS_VEL) && (s_r.control_mode_param != MODE_POS_TRQ)
    |-> !cb.valid && (speed_command_analog == 16'sh0000)
        && (torque_command_analog == 16'sh0000) && (speed_limit_analog == 16'sh0000))
    else $error("Analog input used in another mode");

  a_sample_latency: assert property (
    cb.valid ##1 (!cb.clear)[*2] |=> cb.result_valid)
    else $error("Sample did not reach the result in three cycles");

  a_submode_gate: assert property (
    !second_submode_active |-> !cb.valid ##1 (s_r.fn == FN_NONE))
    else $error("Analog function active outside its sub-mode");

  c_quad_count:   cover property (is_quad && edge_a ##1 is_quad && edge_b);
  c_speed_result: cover property ((s_r.fn == FN_SPEED) && cb.result_valid);
  c_torque_result: cover property ((s_r.fn == FN_TORQUE) && cb.result_valid);
  c_limit_result: cover property ((s_r.fn == FN_LIMIT) && cb.result_valid);

endmodule // servo_command_input_select
`default_nettype wire

//--- rtl/servo_cmd_pkg.sv
/*
  Constants and types for the servo command input front end.
  Assumes nothing beyond a SystemVerilog compiler; no timescale here.
*/
package servo_cmd_pkg;

  // Register bus widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Register offsets
  localparam logic [3:0] CTRL_OFS         = 4'h0;
  localparam logic [3:0] SPEED_GAIN_OFS   = 4'h1;
  localparam logic [3:0] SPEED_INV_OFS    = 4'h2;
  localparam logic [3:0] OFFSET_OFS       = 4'h3;
  localparam logic [3:0] FILTER_OFS       = 4'h4;
  localparam logic [3:0] TORQUE_GAIN_OFS  = 4'h5;
  localparam logic [3:0] TORQUE_INV_OFS   = 4'h6;
  localparam logic [3:0] COUNT_LO_OFS     = 4'h8;
  localparam logic [3:0] COUNT_HI_OFS     = 4'h9;
  localparam logic [3:0] STATUS_OFS       = 4'hA;
  localparam logic [3:0] RESULT_OFS       = 4'hB;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TSEL_BIT = 4;
  localparam int CTRL_FMT_LSB  = 5;
  localparam int CTRL_CLR_BIT  = 7;

  // Reset values
  localparam logic [3:0]  MODE_RST   = 4'h0;
  localparam logic [1:0]  FMT_RST    = 2'h1;
  localparam logic [15:0] GAIN_RST   = 16'h0100;
  localparam logic [3:0]  FILTER_RST = 4'h0;

  // Gain is unsigned with this many fraction bits
  localparam int GAIN_FRAC = 8;

  // Control modes that use the shared analog input
  localparam logic [3:0] MODE_POS_VEL = 4'h3;
  localparam logic [3:0] MODE_POS_TRQ = 4'h4;

  // Command pulse formats
  localparam logic [1:0] FMT_QUAD_A     = 2'h0;
  localparam logic [1:0] FMT_CW_CCW     = 2'h1;
  localparam logic [1:0] FMT_QUAD_B     = 2'h2;
  localparam logic [1:0] FMT_PULSE_SIGN = 2'h3;

  // Function given to the analog input
  typedef enum logic [1:0] {
    FN_NONE,
    FN_SPEED,
    FN_TORQUE,
    FN_LIMIT
  } func_type;

endpackage

//--- rtl/cond_if.sv
/*
  Link between the input selector and the analog conditioner.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
  logic signed [15:0] sample;
  logic               valid;
  logic               clear;
  logic        [15:0] gain;
  logic               invert;
  logic signed [15:0] offset;
  logic        [3:0]  filter_shift;
  logic signed [15:0] result;
  logic               result_valid;

  modport source (output sample, valid, clear, gain, invert, offset, filter_shift,
                  input result, result_valid);
  modport sink   (input sample, valid, clear, gain, invert, offset, filter_shift,
                  output result, result_valid);
endinterface
`default_nettype wire

//--- rtl/analog_conditioner.sv
/*
  Offset, polarity, gain and first-order filter for the digitized analog command.
  Assumes a synchronised active-low reset and parameters held stable by the selector.
*/
`timescale 1ns/1ps
`default_nettype none
module analog_conditioner
  import servo_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_sync_n,
  // Selector side
  cond_if.sink      c
);

  typedef struct packed {
    logic signed [15:0] x1;
    logic               v1;
    logic signed [15:0] x2;
    logic               v2;
    logic signed [15:0] y;
    logic               yv;
  } cond_state_type;

  cond_state_type s_r;
  cond_state_type s_nxt;

  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      return 16'sh7FFF;
    end else if (v < -34'sd32768) begin
      return 16'sh8000;
    end else begin
      return v[15:0];
    end
  endfunction

  logic signed [33:0] sum;
  logic signed [33:0] prod;
  logic signed [33:0] diff;

  always_comb begin
    s_nxt = s_r;
    // Offset then polarity
    sum  = 34'(c.sample) + 34'(c.offset);
    s_nxt.v1 = c.valid;
    if (c.valid) begin
      s_nxt.x1 = sat16(c.invert ? -sum : sum);
    end
    // Gain
    prod = (34'(s_r.x1) * 34'($signed({1'b0, c.gain}))) >>> GAIN_FRAC;
    s_nxt.v2 = s_r.v1;
    if (s_r.v1) begin
      s_nxt.x2 = sat16(prod);
    end
    // Filter
    diff = 34'(s_r.x2) - 34'(s_r.y);
    s_nxt.yv = s_r.v2;
    if (s_r.v2) begin
      s_nxt.y = sat16(34'(s_r.y) + (diff >>> c.filter_shift));
    end
    if (c.clear) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign c.result       = s_r.y;
  assign c.result_valid = s_r.yv;

endmodule // analog_conditioner
`default_nettype wire

//--- verif/host_cmd_model.sv
/*
  Host motion controller model driving the command pulse lines.
  Assumes the caller starts each task just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model #(
  parameter int HOLD_CYC = 63
) (
  // Clock
  input  wire logic clock,
  // Command lines
  output var  logic command_pulse_line,
  output var  logic command_sign_line
);
  logic [1:0] step;

  initial begin
    command_pulse_line = 1'b0;
    command_sign_line  = 1'b0;
    step               = 2'h0;
  end

  // Every level is held long enough for the fastest interface
  task automatic hold_level();
    repeat (HOLD_CYC) @(posedge clock);
  endtask

  // Both lines low, quadrature phase back to its start
  task automatic idle();
    command_pulse_line <= 1'b0;
    command_sign_line  <= 1'b0;
    step = 2'h0;
    hold_level();
  endtask

  // Sends n pulses (quadrature: n edges), forward or reverse
  task automatic send(input logic [1:0] fmt, input int n, input bit fwd);
    for (int i = 0; i < n; i++) begin
      if (fmt == 2'h1) begin
        if (fwd) command_pulse_line <= 1'b1;
        else command_sign_line <= 1'b1;
        hold_level();
        command_pulse_line <= 1'b0;
        command_sign_line  <= 1'b0;
        hold_level();
      end else if (fmt == 2'h3) begin
        command_sign_line <= ~fwd;
        hold_level();
        command_pulse_line <= 1'b1;
        hold_level();
        command_pulse_line <= 1'b0;
        hold_level();
      end else begin
        step = fwd ? step + 2'h1 : step - 2'h1;
        command_pulse_line <= step[1];
        command_sign_line  <= step[1] ^ step[0];
        hold_level();
      end
    end
  endtask
endmodule // host_cmd_model
`default_nettype wire

//--- verif/servo_command_input_select_test.sv
/*
  Self-checking testbench for the servo command input front end.
  Assumes the register map and conditioner latency of the design package.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_command_input_select_test
  import servo_cmd_pkg::*;
;
  logic               clock, rst_n, reg_write, reg_read, adc_valid, second_submode_active;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata, reg_rdata, d;
  logic signed [15:0] adc_sample, spd, trq, lim;
  logic signed [31:0] pos;
  logic               pulse_w, sign_w;
  int                 err_count, cmp_count;

  servo_command_input_select dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .command_pulse_line(pulse_w), .command_sign_line(sign_w),
    .adc_sample(adc_sample), .adc_valid(adc_valid),
    .second_submode_active(second_submode_active),
    .speed_command_analog(spd), .torque_command_analog(trq),
    .speed_limit_analog(lim), .pulse_position(pos));

  host_cmd_model #(.HOLD_CYC(63)) host (
    .clock(clock), .command_pulse_line(pulse_w), .command_sign_line(sign_w));

  initial clock = 1'b0;
  always #2 clock = ~clock;

  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
    @(posedge clock);
  endtask

  task automatic cfg(input logic [3:0] m, input logic t, input logic sub);
    reg_wr(CTRL_OFS, {8'h00, 1'b0, FMT_CW_CCW, t, m});
    second_submode_active <= sub;
    repeat (3) @(posedge clock);
  endtask

  // One sample in, all three outputs judged four cycles later
  task automatic sample_check(input logic [15:0] s, input logic [15:0] es, et, el);
    @(posedge clock);
    adc_sample <= s;
    adc_valid  <= 1'b1;
    @(posedge clock);
    adc_valid  <= 1'b0;
    adc_sample <= ~s;
    repeat (4) @(posedge clock);
    #1;
    check16(spd, es, "speed output");
    check16(trq, et, "torque output");
    check16(lim, el, "limit output");
  endtask

  task automatic test_reset();
    reg_rd(CTRL_OFS, d);
    check16(d, 16'h0020, "control reset");
    reg_rd(SPEED_GAIN_OFS, d);
    check16(d, GAIN_RST, "speed gain reset");
    reg_rd(TORQUE_GAIN_OFS, d);
    check16(d, GAIN_RST, "torque gain reset");
    reg_wr(4'h7, 16'hFFFF);
    reg_rd(4'h7, d);
    check16(d, 16'h0000, "unmapped read");
    check32(pos, 32'h0000_0000, "position reset");
  endtask

  task automatic test_pulses();
    for (int f = 0; f < 4; f++) begin
      host.idle();
      reg_wr(CTRL_OFS, {8'h00, 1'b1, 2'(f), 5'h00});
      host.send(2'(f), 2, 1'b1);
      host.send(2'(f), 4, 1'b0);
      reg_rd(CTRL_OFS, d);
      check16(d, {9'h000, 2'(f), 5'h00}, "format readback");
      reg_rd(COUNT_LO_OFS, d);
      check16(d, 16'hFFFE, "count low");
      reg_rd(COUNT_HI_OFS, d);
      check16(d, 16'hFFFF, "count high");
      check32(pos, 32'hFFFF_FFFE, "position");
    end
  endtask

  task automatic test_speed();
    reg_wr(SPEED_GAIN_OFS, 16'h0200);
    reg_wr(SPEED_INV_OFS, 16'h0001);
    reg_wr(OFFSET_OFS, 16'h0010);
    reg_rd(OFFSET_OFS, d);
    check16(d, 16'h0010, "offset readback");
    reg_wr(FILTER_OFS, 16'h0000);
    cfg(MODE_POS_VEL, 1'b0, 1'b1);
    sample_check(16'h0100, 16'hFDE0, 16'h0000, 16'h0000);
    reg_rd(STATUS_OFS, d);
    check16(d & 16'h0003, 16'h0001, "speed function");
    cfg(MODE_POS_VEL, 1'b0, 1'b0);
    sample_check(16'h0100, 16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic test_torque();
    reg_wr(SPEED_INV_OFS, 16'h0000);
    reg_wr(TORQUE_GAIN_OFS, 16'h0080);
    reg_wr(TORQUE_INV_OFS, 16'h0001);
    reg_wr(FILTER_OFS, 16'h0001);
    cfg(MODE_POS_TRQ, 1'b0, 1'b1);
    sample_check(16'h0200, 16'h0000, 16'hFF7C, 16'h0000);
    sample_check(16'h0200, 16'h0000, 16'hFF3A, 16'h0000);
    cfg(MODE_POS_TRQ, 1'b0, 1'b0);
    sample_check(16'h0200, 16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic test_limit();
    reg_wr(SPEED_INV_OFS, 16'h0001);
    reg_wr(FILTER_OFS, 16'h0000);
    cfg(MODE_POS_TRQ, 1'b1, 1'b1);
    sample_check(16'hFF00, 16'h0000, 16'h0000, 16'hFE20);
    reg_rd(RESULT_OFS, d);
    check16(d, 16'hFE20, "result register");
  endtask

  task automatic test_ignored();
    logic [3:0] modes [4];
    modes = '{4'h0, 4'h1, 4'h2, 4'h5};
    foreach (modes[i]) begin
      cfg(modes[i], 1'b0, 1'b1);
      sample_check(16'h0100, 16'h0000, 16'h0000, 16'h0000);
      reg_rd(STATUS_OFS, d);
      check16(d & 16'h0003, 16'h0000, "no function");
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    adc_sample = 16'h0000;
    adc_valid = 1'b0;
    second_submode_active = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    test_reset();
    test_pulses();
    test_speed();
    test_torque();
    test_limit();
    test_ignored();
    tally_and_finish();
  end

  // Run needs under 6000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("unexpected at %0t: run did not complete", $time);
    tally_and_finish();
  end
endmodule // servo_command_input_select_test
`default_nettype wire
